// *** design/ems_consts.svh ***
`ifndef EMS_CONSTS_SVH
`define EMS_CONSTS_SVH

// Register addresses
`define ADDR_HEAT_CORR 8'h00
`define ADDR_HEAT_RANGE 8'h02
`define ADDR_RSW_ERR 8'h04
`define ADDR_STATUS 8'h1d
`define ADDR_PRESS_MSB 8'h1f
`define ADDR_PRESS_LSB 8'h20
`define ADDR_PRESS_XLSB 8'h21
`define ADDR_TEMP_MSB 8'h22
`define ADDR_TEMP_LSB 8'h23
`define ADDR_TEMP_XLSB 8'h24
`define ADDR_HUM_MSB 8'h25
`define ADDR_HUM_LSB 8'h26
`define ADDR_GAS_MSB 8'h2a
`define ADDR_GAS_LSB 8'h2b
`define ADDR_TARGET_BASE 8'h5a
`define ADDR_DURATION_BASE 8'h64
`define ADDR_CTRL_GAS 8'h71
`define ADDR_CTRL_HUM 8'h72
`define ADDR_CTRL_MEAS 8'h74
`define ADDR_CONFIG 8'h75
`define ADDR_CAL_B_LOW 8'heb
`define ADDR_CAL_B_HIGH 8'hec
`define ADDR_CAL_A 8'hed
`define ADDR_CAL_C 8'hee

// Field positions
`define OSRT_MSB 7
`define OSRT_LSB 5
`define OSRP_MSB 4
`define OSRP_LSB 2
`define MODE_MSB 1
`define MODE_LSB 0
`define OSRH_MSB 2
`define OSRH_LSB 0
`define FILT_MSB 4
`define FILT_LSB 2
`define RUN_GAS_BIT 4
`define PROF_MSB 3
`define PROF_LSB 0

// Values
`define NUM_PROFILES 10
`define MODE_SLEEP 2'h0
`define MODE_FORCED 2'h1
`define SKIP_CODE 20'h80000
`define CH_TEMP 2'h0
`define CH_PRESS 2'h1
`define CH_HUM 2'h2
`define CH_GAS 2'h3

// Timing
`define CLK_PERIOD_PS 4000
`define HEAT_TICK_NS 1000000
`define HEAT_TICK_CYCLES ((`HEAT_TICK_NS * 1000) / `CLK_PERIOD_PS)

`endif

// *** design/ems_pkg.sv ***
package ems_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TEMP,
    ST_PRESS,
    ST_HUM,
    ST_HEAT,
    ST_GAS,
    ST_DONE
  } ems_state_t;

endpackage

// *** design/ems_filter_chan.sv ***
`timescale 1ns/1ps
`include "ems_consts.svh"

module ems_filter_chan import ems_pkg::*; #(
  parameter int W = 20,
  parameter int KW = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic flt_reset,
  input wire logic [KW-1:0] coef_shift,
  // Conversion
  input wire logic conv_valid,
  input wire logic conv_skip,
  input wire logic [W-1:0] conv_data,
  // Result
  output logic [W-1:0] result_ff
);

  localparam int AW = W + (2 ** KW);

  logic [W-1:0] mem_ff;
  logic primed_ff;
  logic [AW-1:0] nxt_acc;
  logic [W-1:0] nxt_filt;

  // Coefficient is a power of two, so the divide is a shift
  always_comb begin
    nxt_acc = (AW'(mem_ff) << coef_shift) - AW'(mem_ff) + AW'(conv_data);
    nxt_filt = W'(nxt_acc >> coef_shift);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      primed_ff <= 1'b0;
    end else if (flt_reset) begin
      primed_ff <= 1'b0;
    end else if (conv_valid) begin
      primed_ff <= 1'b1;
    end
  end

  // Skips leave the memory alone so a re-enabled channel resumes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_ff <= '0;
    end else if (conv_valid) begin
      mem_ff <= primed_ff ? nxt_filt : conv_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_ff <= '0;
    end else if (conv_valid) begin
      result_ff <= primed_ff ? nxt_filt : conv_data;
    end else if (conv_skip) begin
      result_ff <= W'(`SKIP_CODE);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_skip_output: assert property (conv_skip && !conv_valid |=> result_ff == W'(`SKIP_CODE))
    else $error("skipped channel result not mid-scale");
  a_skip_memory: assert property (conv_skip && !conv_valid |=> mem_ff == $past(mem_ff))
    else $error("filter memory changed on skip");
  a_reset_pass: assert property (!primed_ff && conv_valid |=> result_ff == $past(conv_data))
    else $error("first value after filter reset altered");
  a_coef_one: assert property (coef_shift == '0 && conv_valid |=> result_ff == $past(conv_data))
    else $error("unity coefficient did not pass value");
  a_result_memory: assert property (conv_valid |=> result_ff == mem_ff)
    else $error("output and filter memory differ");
  a_flt_clear: assert property (flt_reset |=> !primed_ff)
    else $error("filter not reset by coefficient write");

endmodule

// *** design/ems_sequencer.sv ***
// Overview of operation
// - Humidity conversion is skippable; a three-bit field picks its oversampling.
// - Humidity result is the raw 16-bit conversion, never filtered.
// - Only temperature and pressure are filtered, giving 20-bit results.
// - Filtered value is memory times (c-1) plus new sample, over c.
// - Each filtered value updates both filter memory and result registers.
// - Any coefficient register write resets the filter, except one ignored while a mode change is waiting.
// - First sample after filter reset passes unchanged and seeds the memory.
// - Skipped temperature or pressure channel keeps its memory; its result reads 0x80000.
// - Re-enabled channel filters from memory of its last real conversion.
// - Ten heater profiles, each with an eight-bit target code.
// - Target code is a heater resistance, used directly by regulation.
// - Heating starts only after temperature, pressure, humidity finish.
// - Each profile has an eight-bit duration, 1 ms to 4032 ms.
// - Fresh-result flag is set when a new result is ready.
// - Gas-valid and heater-settled status bits are reported.
// - Heater-settled is clear when the plate missed its target.
// - Signed four-bit range switching error sits in 0x04 bits 7:4.
// - A four-bit gas range code accompanies each gas value.
// - Two-bit heater range sits in 0x02 bits 5:4.
// - Signed heater resistance correction reads at 0x00.
// - Mode 01 runs one full cycle, then returns to sleep.
// - Four-bit profile select picks the target and duration used.
// - Gas heating and conversion happen only with gas run enable set.
// - Mode change during a cycle waits; further control writes ignored meanwhile.
`timescale 1ns/1ps
`include "ems_consts.svh"

module ems_sequencer import ems_pkg::*; #(
  parameter int HEAT_TICK = `HEAT_TICK_CYCLES,
  parameter int NPROF = `NUM_PROFILES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  // Trim and calibration values
  input wire logic [7:0] trim_heat_corr,
  input wire logic [1:0] trim_heat_range,
  input wire logic [3:0] trim_rsw_err,
  input wire logic [7:0] trim_cal_a,
  input wire logic [15:0] trim_cal_b,
  input wire logic [7:0] trim_cal_c,
  // Converter
  output logic adc_start_ff,
  output logic [1:0] adc_chan_ff,
  output logic [2:0] adc_osr_ff,
  input wire logic adc_done,
  input wire logic [19:0] adc_data,
  input wire logic [3:0] adc_gas_range,
  // Heater
  output logic heater_on_ff,
  output logic [7:0] heater_target_ff,
  input wire logic heater_at_target,
  // Status
  output logic measuring_ff
);

  localparam int TW = $clog2(HEAT_TICK + 1);

  ems_state_t st_ff;
  ems_state_t cur_next;
  logic [2:0] osrs_t_ff, osrs_p_ff, osrs_h_ff, filter_ff;
  logic [1:0] mode_ff, pend_mode_ff;
  logic pend_ff, run_gas_ff, issued_ff;
  logic [3:0] profile_ff;
  logic [7:0] target_ff [NPROF];
  logic [7:0] dur_ff [NPROF];
  logic [15:0] hum_ff;
  logic [9:0] gas_r_ff;
  logic [3:0] gas_range_ff;
  logic new_data_ff, gas_valid_ff, heat_stab_ff;
  logic [TW-1:0] div_ff;
  logic [12:0] ms_cnt_ff;
  logic [12:0] heat_len;
  logic [7:0] cur_dur;
  logic ms_tick, heat_over, busy, wr_ok, meas_wr, flt_reset, gas_en;
  logic [2:0] cur_osr;
  logic [1:0] cur_chan;
  logic conv_done, t_valid, p_valid, t_skip, p_skip;
  logic [19:0] temp_res, press_res;

  assign busy = st_ff != ST_IDLE;
  // Once a mode change is waiting, the control registers are frozen
  assign wr_ok = reg_wr && !pend_ff;
  assign meas_wr = wr_ok && reg_addr == `ADDR_CTRL_MEAS;
  assign flt_reset = wr_ok && reg_addr == `ADDR_CONFIG;
  assign gas_en = run_gas_ff && profile_ff < 4'(NPROF);
  assign conv_done = issued_ff && adc_done;

  always_comb begin
    cur_osr = 3'h0;
    cur_chan = `CH_TEMP;
    cur_next = st_ff;
    unique case (st_ff)
      ST_TEMP: begin
        cur_osr = osrs_t_ff;
        cur_chan = `CH_TEMP;
        cur_next = ST_PRESS;
      end
      ST_PRESS: begin
        cur_osr = osrs_p_ff;
        cur_chan = `CH_PRESS;
        cur_next = ST_HUM;
      end
      ST_HUM: begin
        cur_osr = osrs_h_ff;
        cur_chan = `CH_HUM;
        cur_next = gas_en ? ST_HEAT : ST_DONE;
      end
      ST_GAS: begin
        cur_osr = 3'h1;
        cur_chan = `CH_GAS;
        cur_next = ST_DONE;
      end
      ST_IDLE, ST_HEAT, ST_DONE: begin
        cur_next = st_ff;
      end
    endcase
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      osrs_t_ff <= 3'h0;
      osrs_p_ff <= 3'h0;
      osrs_h_ff <= 3'h0;
      filter_ff <= 3'h0;
      run_gas_ff <= 1'b0;
      profile_ff <= 4'h0;
    end else if (wr_ok) begin
      unique case (reg_addr)
        `ADDR_CTRL_MEAS: begin
          osrs_t_ff <= reg_wdata[`OSRT_MSB:`OSRT_LSB];
          osrs_p_ff <= reg_wdata[`OSRP_MSB:`OSRP_LSB];
        end
        `ADDR_CTRL_HUM: osrs_h_ff <= reg_wdata[`OSRH_MSB:`OSRH_LSB];
        `ADDR_CONFIG: filter_ff <= reg_wdata[`FILT_MSB:`FILT_LSB];
        `ADDR_CTRL_GAS: begin
          run_gas_ff <= reg_wdata[`RUN_GAS_BIT];
          profile_ff <= reg_wdata[`PROF_MSB:`PROF_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // Heater profiles
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < NPROF; i++) begin
        target_ff[i] <= 8'h00;
        dur_ff[i] <= 8'h00;
      end
    end else if (wr_ok) begin
      for (int i = 0; i < NPROF; i++) begin
        if (reg_addr == `ADDR_TARGET_BASE + 8'(i)) begin
          target_ff[i] <= reg_wdata;
        end
        if (reg_addr == `ADDR_DURATION_BASE + 8'(i)) begin
          dur_ff[i] <= reg_wdata;
        end
      end
    end
  end

  // Mode, with deferral of a change that arrives mid-cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_ff <= `MODE_SLEEP;
      pend_ff <= 1'b0;
      pend_mode_ff <= `MODE_SLEEP;
    end else if (st_ff == ST_DONE) begin
      pend_ff <= 1'b0;
      if (meas_wr) begin
        mode_ff <= reg_wdata[`MODE_MSB:`MODE_LSB];
      end else if (pend_ff) begin
        mode_ff <= pend_mode_ff;
      end else begin
        mode_ff <= `MODE_SLEEP;
      end
    end else if (meas_wr && busy) begin
      pend_ff <= 1'b1;
      pend_mode_ff <= reg_wdata[`MODE_MSB:`MODE_LSB];
    end else if (meas_wr) begin
      mode_ff <= reg_wdata[`MODE_MSB:`MODE_LSB];
    end
  end

  // Sequencer and converter requests
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff <= ST_IDLE;
      issued_ff <= 1'b0;
      adc_start_ff <= 1'b0;
      adc_chan_ff <= `CH_TEMP;
      adc_osr_ff <= 3'h0;
    end else begin
      adc_start_ff <= 1'b0;
      unique case (st_ff)
        ST_IDLE: begin
          if (mode_ff == `MODE_FORCED) begin
            st_ff <= ST_TEMP;
          end
        end
        ST_TEMP, ST_PRESS, ST_HUM, ST_GAS: begin
          if (cur_osr == 3'h0) begin
            st_ff <= cur_next;
          end else if (!issued_ff) begin
            adc_start_ff <= 1'b1;
            adc_chan_ff <= cur_chan;
            adc_osr_ff <= cur_osr;
            issued_ff <= 1'b1;
          end else if (adc_done) begin
            issued_ff <= 1'b0;
            st_ff <= cur_next;
          end
        end
        ST_HEAT: begin
          if (heat_over) begin
            st_ff <= ST_GAS;
          end
        end
        ST_DONE: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Millisecond enable and heating time; a zero code still heats one tick
  always_comb begin
    cur_dur = gas_en ? dur_ff[profile_ff] : 8'h00;
    heat_len = 13'({7'h00, cur_dur[5:0]} << {cur_dur[7:6], 1'b0});
    if (heat_len == 13'h0) begin
      heat_len = 13'h1;
    end
  end
  assign ms_tick = st_ff == ST_HEAT && div_ff == TW'(HEAT_TICK - 1);
  assign heat_over = ms_tick && ms_cnt_ff == heat_len - 13'h1;

  always_ff @(posedge ref_clk) begin
    if (reset || st_ff != ST_HEAT) begin
      div_ff <= '0;
      ms_cnt_ff <= 13'h0;
    end else if (ms_tick) begin
      div_ff <= '0;
      ms_cnt_ff <= ms_cnt_ff + 13'h1;
    end else begin
      div_ff <= div_ff + TW'(1);
    end
  end

  // Heater drive; the code is a resistance setpoint for the regulation loop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      heater_on_ff <= 1'b0;
      heater_target_ff <= 8'h00;
    end else begin
      heater_on_ff <= st_ff == ST_HEAT || st_ff == ST_GAS;
      if (st_ff == ST_HEAT) begin
        heater_target_ff <= target_ff[profile_ff];
      end
    end
  end

  // Filtered channels
  assign t_valid = st_ff == ST_TEMP && conv_done;
  assign p_valid = st_ff == ST_PRESS && conv_done;
  assign t_skip = st_ff == ST_TEMP && osrs_t_ff == 3'h0;
  assign p_skip = st_ff == ST_PRESS && osrs_p_ff == 3'h0;

  ems_filter_chan #(.W(20), .KW(3)) u_temp_filt (
    .ref_clk(ref_clk),
    .reset(reset),
    .flt_reset(flt_reset),
    .coef_shift(filter_ff),
    .conv_valid(t_valid),
    .conv_skip(t_skip),
    .conv_data(adc_data),
    .result_ff(temp_res)
  );

  ems_filter_chan #(.W(20), .KW(3)) u_press_filt (
    .ref_clk(ref_clk),
    .reset(reset),
    .flt_reset(flt_reset),
    .coef_shift(filter_ff),
    .conv_valid(p_valid),
    .conv_skip(p_skip),
    .conv_data(adc_data),
    .result_ff(press_res)
  );

  // Unfiltered results and status
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hum_ff <= 16'h0000;
      gas_r_ff <= 10'h000;
      gas_range_ff <= 4'h0;
      new_data_ff <= 1'b0;
      gas_valid_ff <= 1'b0;
      heat_stab_ff <= 1'b0;
      measuring_ff <= 1'b0;
    end else begin
      measuring_ff <= busy;
      if (st_ff == ST_IDLE && mode_ff == `MODE_FORCED) begin
        new_data_ff <= 1'b0;
        gas_valid_ff <= 1'b0;
        heat_stab_ff <= 1'b0;
      end
      if (st_ff == ST_HUM && conv_done) begin
        hum_ff <= adc_data[15:0];
      end
      if (heat_over) begin
        heat_stab_ff <= heater_at_target;
      end
      if (st_ff == ST_GAS && conv_done) begin
        gas_r_ff <= adc_data[9:0];
        gas_range_ff <= adc_gas_range;
        gas_valid_ff <= 1'b1;
      end
      if (st_ff == ST_DONE) begin
        new_data_ff <= 1'b1;
      end
    end
  end

  // Register reads, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= 8'h00;
      for (int i = 0; i < NPROF; i++) begin
        if (reg_addr == `ADDR_TARGET_BASE + 8'(i)) begin
          reg_rdata_ff <= target_ff[i];
        end
        if (reg_addr == `ADDR_DURATION_BASE + 8'(i)) begin
          reg_rdata_ff <= dur_ff[i];
        end
      end
      unique case (reg_addr)
        `ADDR_HEAT_CORR: reg_rdata_ff <= trim_heat_corr;
        `ADDR_HEAT_RANGE: reg_rdata_ff <= {2'h0, trim_heat_range, 4'h0};
        `ADDR_RSW_ERR: reg_rdata_ff <= {trim_rsw_err, 4'h0};
        `ADDR_STATUS: reg_rdata_ff <= {new_data_ff, st_ff == ST_HEAT || st_ff == ST_GAS, busy, 1'b0, profile_ff};
        `ADDR_PRESS_MSB: reg_rdata_ff <= press_res[19:12];
        `ADDR_PRESS_LSB: reg_rdata_ff <= press_res[11:4];
        `ADDR_PRESS_XLSB: reg_rdata_ff <= {press_res[3:0], 4'h0};
        `ADDR_TEMP_MSB: reg_rdata_ff <= temp_res[19:12];
        `ADDR_TEMP_LSB: reg_rdata_ff <= temp_res[11:4];
        `ADDR_TEMP_XLSB: reg_rdata_ff <= {temp_res[3:0], 4'h0};
        `ADDR_HUM_MSB: reg_rdata_ff <= hum_ff[15:8];
        `ADDR_HUM_LSB: reg_rdata_ff <= hum_ff[7:0];
        `ADDR_GAS_MSB: reg_rdata_ff <= gas_r_ff[9:2];
        `ADDR_GAS_LSB: reg_rdata_ff <= {gas_r_ff[1:0], gas_valid_ff, heat_stab_ff, gas_range_ff};
        `ADDR_CTRL_GAS: reg_rdata_ff <= {3'h0, run_gas_ff, profile_ff};
        `ADDR_CTRL_HUM: reg_rdata_ff <= {5'h00, osrs_h_ff};
        `ADDR_CTRL_MEAS: reg_rdata_ff <= {osrs_t_ff, osrs_p_ff, mode_ff};
        `ADDR_CONFIG: reg_rdata_ff <= {3'h0, filter_ff, 2'h0};
        `ADDR_CAL_B_LOW: reg_rdata_ff <= trim_cal_b[7:0];
        `ADDR_CAL_B_HIGH: reg_rdata_ff <= trim_cal_b[15:8];
        `ADDR_CAL_A: reg_rdata_ff <= trim_cal_a;
        `ADDR_CAL_C: reg_rdata_ff <= trim_cal_c;
        default: begin
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_cycle_end;
    st_ff == ST_DONE && !pend_ff && !meas_wr;
  endsequence

  a_no_heat_convert: assert property ((st_ff inside {ST_TEMP, ST_PRESS, ST_HUM}) |-> !heater_on_ff)
    else $error("heater on during conversion");
  a_forced_returns: assert property (s_cycle_end |=> mode_ff == `MODE_SLEEP ##1 st_ff == ST_IDLE)
    else $error("forced cycle did not return to sleep");
  a_gas_gated: assert property (st_ff == ST_HEAT |-> run_gas_ff && profile_ff < 4'(NPROF))
    else $error("heating without gas enable");
  a_new_data_set: assert property (st_ff == ST_DONE |=> new_data_ff)
    else $error("fresh flag not set at cycle end");
  a_hum_raw: assert property (st_ff == ST_HUM && conv_done |=> hum_ff == $past(adc_data[15:0]))
    else $error("humidity result altered");
  a_write_frozen: assert property (pend_ff && reg_wr |=> $stable(filter_ff) && $stable(profile_ff))
    else $error("control write taken while change pending");
  a_settle_capture: assert property (heat_over |=> heat_stab_ff == $past(heater_at_target))
    else $error("settled flag not from heater state");
  a_gas_result: assert property (st_ff == ST_GAS && conv_done |=>
    gas_valid_ff && gas_range_ff == $past(adc_gas_range))
    else $error("gas range or valid not captured");

endmodule

// *** tb/ems_conv_model.sv ***
`timescale 1ns/1ps
module ems_conv_model (
  // Clock
  input wire logic ref_clk,
  // Converter
  input wire logic adc_start_ff,
  input wire logic [1:0] adc_chan_ff,
  output logic adc_done,
  output logic [19:0] adc_data,
  output logic [3:0] adc_gas_range,
  // Heater
  input wire logic heater_on_ff,
  output logic heater_at_target,
  // Bench control
  input wire logic [79:0] samples,
  input wire logic [3:0] gas_range,
  input wire logic settle,
  output int gas_starts,
  output int heat_clash
);
  int wait_n;

  initial begin
    adc_done = 1'b0;
    adc_data = 20'h00000;
    adc_gas_range = 4'h0;
    wait_n = 0;
    gas_starts = 0;
    heat_clash = 0;
  end

  assign heater_at_target = settle;

  // Random latency so the sequencer must wait for done, not count cycles
  always @(posedge ref_clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (heater_on_ff && (adc_start_ff || wait_n > 0) && adc_chan_ff != 2'h3) begin
      heat_clash <= heat_clash + 1;
    end
    if (adc_start_ff) begin
      if (adc_chan_ff == 2'h3) begin
        gas_starts <= gas_starts + 1;
      end
      wait_n <= 1 + ($urandom % 4);
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
      if (wait_n == 1) begin
        adc_done <= 1'b1;
        adc_data <= samples[adc_chan_ff * 20 +: 20];
        adc_gas_range <= gas_range;
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench import ems_pkg::*;;
  localparam int TICK = 4;
  logic ref_clk, reset, reg_wr, reg_rd, settle;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, corr, cal_a, cal_c, heater_target_ff;
  logic [15:0] cal_b;
  logic [1:0] hrange, adc_chan_ff;
  logic [3:0] rsw, grange, adc_gas_range;
  logic adc_start_ff, adc_done, heater_on_ff, heater_at_target, measuring_ff;
  logic [2:0] adc_osr_ff;
  logic [19:0] adc_data;
  logic [79:0] samples;
  int gas_starts, heat_clash, err_count, total_checks, gexp, fcode;
  int mem[2], primed[2], osr[4], tgt[10], dur[10], res[3];

  ems_sequencer #(.HEAT_TICK(TICK)) uut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .trim_heat_corr(corr), .trim_heat_range(hrange), .trim_rsw_err(rsw), .trim_cal_a(cal_a),
    .trim_cal_b(cal_b), .trim_cal_c(cal_c), .adc_start_ff(adc_start_ff), .adc_chan_ff(adc_chan_ff),
    .adc_osr_ff(adc_osr_ff), .adc_done(adc_done), .adc_data(adc_data), .adc_gas_range(adc_gas_range),
    .heater_on_ff(heater_on_ff), .heater_target_ff(heater_target_ff),
    .heater_at_target(heater_at_target), .measuring_ff(measuring_ff));

  ems_conv_model conv (.ref_clk(ref_clk), .adc_start_ff(adc_start_ff), .adc_chan_ff(adc_chan_ff),
    .adc_done(adc_done), .adc_data(adc_data), .adc_gas_range(adc_gas_range),
    .heater_on_ff(heater_on_ff), .heater_at_target(heater_at_target), .samples(samples),
    .gas_range(grange), .settle(settle), .gas_starts(gas_starts), .heat_clash(heat_clash));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata_ff;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check({24'h0, d}, {24'h0, e});
  endtask

  task automatic rd3(input logic [7:0] a, input logic [19:0] e);
    rchk(a, e[19:12]);
    rchk(a + 8'h1, e[11:4]);
    rchk(a + 8'h2, {e[3:0], 4'h0});
  endtask

  // Integer model of the smoothing filter; c is a power of two so the divide is a shift
  function automatic int filt(input int ch, input int x);
    if (!primed[ch]) mem[ch] = x;
    else mem[ch] = (mem[ch] * ((1 << fcode) - 1) + x) >> fcode;
    primed[ch] = 1;
    return mem[ch];
  endfunction

  function automatic int dms(input logic [7:0] c);
    int m;
    m = (c[5:0] == 6'h0) ? 1 : int'(c[5:0]);
    return m << (2 * c[7:6]);
  endfunction

  task automatic run(input int ot, op, oh, gen, prof, fw, ncyc);
    int n, falls, hcnt, g;
    logic prev;
    logic [7:0] b0;
    samples <= 80'({$urandom, $urandom, $urandom});
    grange <= 4'($urandom);
    settle <= 1'($urandom);
    osr = '{ot, op, oh, 1};
    if (fw) begin
      fcode = $urandom % 8;
      wr(8'h75, 8'(fcode << 2));
      primed = '{0, 0};
    end
    wr(8'h72, 8'(oh));
    wr(8'h71, 8'((gen << 4) | prof));
    wr(8'h74, 8'((ot << 5) | (op << 2) | 1));
    if (ncyc == 2) begin
      for (n = 0; n < 100 && !measuring_ff; n++) @(posedge ref_clk);
      check(measuring_ff, 1);
      wr(8'h74, 8'((ot << 5) | (op << 2) | 1));
      wr(8'h75, 8'((fcode << 2) ^ 8'h1c));
    end
    falls = 0;
    hcnt = 0;
    prev = measuring_ff;
    for (n = 0; n < 50000 && falls < ncyc; n++) begin
      @(posedge ref_clk);
      #1;
      if (adc_start_ff) begin
        check(adc_osr_ff, osr[adc_chan_ff]);
        if (adc_chan_ff == 2'h3) begin
          check(hcnt >= dms(dur[prof]) * TICK && hcnt <= dms(dur[prof]) * TICK + 3, 1);
          check(heater_target_ff, tgt[prof]);
        end
      end
      hcnt = heater_on_ff ? hcnt + 1 : 0;
      if (prev && !measuring_ff) falls++;
      prev = measuring_ff;
    end
    if (falls < ncyc) begin
      check(0, 1);
      print_verdict();
    end
    for (n = 0; n < ncyc; n++) begin
      res[0] = ot ? filt(0, samples[19:0]) : 'h80000;
      res[1] = op ? filt(1, samples[39:20]) : 'h80000;
      if (oh) res[2] = samples[55:40];
    end
    g = (gen && prof < 10);
    gexp += g * ncyc;
    rd3(8'h22, res[0]);
    rd3(8'h1f, res[1]);
    rchk(8'h25, 8'(res[2] >> 8));
    rchk(8'h26, 8'(res[2]));
    if (g) rchk(8'h2a, samples[69:62]);
    rd(8'h2b, b0);
    check(b0[5:4], g ? {1'b1, settle} : 2'b00);
    if (g) check({b0[7:6], b0[3:0]}, {samples[61:60], grange});
    rd(8'h1d, b0);
    check(b0, {1'b1, 3'h0, 4'(prof)});
    rchk(8'h74, 8'((ot << 5) | (op << 2)));
    rchk(8'h75, 8'(fcode << 2));
    check(gas_starts, gexp);
  endtask

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {corr, hrange, rsw, cal_a, cal_b, cal_c} = '0;
    samples = '0;
    grange = 4'h0;
    settle = 1'b0;
    void'($urandom(32'h5c6448a6));
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    {corr, hrange, rsw, cal_a, cal_b, cal_c} <= 46'({$urandom, $urandom});
    rchk(8'h74, 8'h00);
    rchk(8'h00, corr);
    rchk(8'h02, {2'b00, hrange, 4'h0});
    rchk(8'h04, {rsw, 4'h0});
    rchk(8'hed, cal_a);
    rchk(8'heb, cal_b[7:0]);
    rchk(8'hec, cal_b[15:8]);
    rchk(8'hee, cal_c);
    rchk(8'h10, 8'h00);
    // Code 0, both ends of the multiplier and plain ms values
    for (int i = 0; i < 10; i++) begin
      tgt[i] = $urandom % 256;
      dur[i] = i == 9 ? 'hc1 : i < 5 ? i : 'h40 + i;
      wr(8'h5a + 8'(i), 8'(tgt[i]));
      wr(8'h64 + 8'(i), 8'(dur[i]));
    end
    for (int i = 0; i < 10; i++) begin
      rchk(8'h5a + 8'(i), 8'(tgt[i]));
      rchk(8'h64 + 8'(i), 8'(dur[i]));
    end
    for (int i = 0; i < 14; i++) begin
      run(i % 4 == 1 ? 0 : 1 + $urandom % 5, i % 4 == 2 ? 0 : 1 + $urandom % 5, $urandom % 6,
          i % 3 != 0, i == 7 ? 10 : $urandom % 10, i % 4 == 0, 1);
    end
    run(1, 2, 1, 1, 9, 0, 2);
    check(heat_clash, 0);
    print_verdict();
  end
endmodule
